// File: verilog/rtot_params.svh
// Register map, field positions, reset values and counts of the reload timer
`ifndef RTOT_PARAMS_SVH
`define RTOT_PARAMS_SVH

// Register byte offsets
`define RTOT_ADDR_CTRL 4'h0
`define RTOT_ADDR_COUNT 4'h4
`define RTOT_ADDR_RELOAD 4'h8
`define RTOT_ADDR_STATUS 4'hc

// Control register fields
`define RTOT_CTRL_EN_BIT 0
`define RTOT_CTRL_MODE_BIT 1
`define RTOT_CTRL_PRE_LSB 2
`define RTOT_CTRL_PRE_MSB 4
`define RTOT_CTRL_POL_BIT 5
`define RTOT_CTRL_OUTEN_BIT 6

// Status register fields
`define RTOT_STAT_EN_BIT 0
`define RTOT_STAT_OUT_BIT 1

// Reset values
`define RTOT_CTRL_RST 8'h00
`define RTOT_COUNT_RST 16'h0000
`define RTOT_RELOAD_RST 16'h0000

// Counter constants
`define RTOT_COUNT_RESTART 16'h0001
`define RTOT_COUNT_STEP 16'h0001
`define RTOT_PRE_MAX_EXP 3'h7
`define RTOT_PRE_ALL_ONES 7'h7f

`endif

// File: verilog/rtot_pkg.sv
// Types shared by the reload timer modules
package rtot_pkg;

  // Operating mode of the timer
  typedef enum logic [0:0] {
    RTOT_MODE_ONESHOT = 1'b0,
    RTOT_MODE_CONT = 1'b1
  } rtot_mode_e;

  // Prescale exponent: divide by two to this power
  typedef logic [2:0] rtot_presc_t;

endpackage : rtot_pkg

// File: verilog/rtot_presc_if.sv
// Link between the timer core and its prescaler
`timescale 1ns/1ps
interface rtot_presc_if;
  import rtot_pkg::*;
  logic en;
  rtot_presc_t exp_sel;
  logic tick;

  // Timer side drives enable and divider, takes the tick
  modport timer (output en, output exp_sel, input tick);
  // Prescaler side
  modport presc (input en, input exp_sel, output tick);
endinterface : rtot_presc_if

// File: verilog/rtot_prescaler.sv
// Prescaler giving one tick every 1 to 128 system clock cycles
`timescale 1ns/1ps
`include "rtot_params.svh"
module rtot_prescaler #(
  parameter int PRE_W = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Timer link
  rtot_presc_if.presc link
);
  import rtot_pkg::*;

  logic [PRE_W-1:0] cnt_ff;
  logic [PRE_W-1:0] limit;

  // Terminal count is two to the exponent, minus one
  assign limit = PRE_W'(`RTOT_PRE_ALL_ONES >> (`RTOT_PRE_MAX_EXP - link.exp_sel)); // [R2]
  assign link.tick = link.en & (cnt_ff == limit); // [R13]

  // Held at zero while disabled so the first tick is a full interval away
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (!link.en) begin
      cnt_ff <= '0; // [R18]
    end else if (link.tick) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + PRE_W'(1);
    end
  end

endmodule : rtot_prescaler

// File: verilog/rtot_timer.sv
// Reload timer with one-shot and continuous modes behind a Wishbone slave
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rtot_params.svh"

//
// Function
// R1: Sixteen-bit up counter, one step per tick
// R2: Prescale selectable from 1 to 128
// R3: Count wraps from FFFF to 0000
// R4: Reload 0000 gives the longest time-out
// R5: Reload 0001, prescale 1 gives shortest time-out
// R6: One-shot match raises request, loads 0001
// R7: One-shot match clears the enable bit
// R8: One-shot output inverts for one cycle
// R9: Software flips polarity after start for lasting change
// R10: Continuous match raises request, loads 0001, continues
// R11: Continuous output toggles and holds per reload
// R12: Written start count affects first pass only
// R13: Ticks come from the prescaled system clock
// R14: External input must stay below quarter clock; the timer has no external input, ticks come only from the prescaled clock
// R15: Software configures fully before setting enable
// R16: First pass lasts reload minus start plus one ticks
// R17: Later continuous passes last reload ticks
// R18: Prescaler cleared while the timer is disabled
module rtot_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Time-out request to the interrupt controller
  output logic timer_irq_o,
  // Timer output alternate function
  output logic timer_out_o,
  output logic timer_out_oe_o
);
  import rtot_pkg::*;

  // Control fields
  logic en_ff;
  rtot_mode_e mode_ff;
  rtot_presc_t presc_ff;
  logic output_polarity_select_ff;
  logic out_en_ff;

  // Counter state
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] reload_ff;

  // Output pin state
  logic level_ff;
  logic out_ff;
  logic irq_ff;

  // Bus state
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Decoded bus request
  logic bus_req;
  logic wr_req;
  logic rd_req;
  logic hit_ctrl;
  logic hit_count;
  logic hit_reload;
  logic hit_status;

  // Timer events
  logic tick;
  logic match;
  logic reload_evt;
  logic oneshot_evt;
  logic [CNT_W-1:0] count_inc;
  logic [7:0] ctrl_rd;

  // Prescaler link
  rtot_presc_if presc_link ();

  rtot_prescaler #(
    .PRE_W(7)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .link(presc_link.presc)
  );

  // Prescaler runs only while enabled
  assign presc_link.en = en_ff; // [R18]
  assign presc_link.exp_sel = presc_ff; // [R2]
  assign tick = presc_link.tick; // [R13]

  // A request is served once; ack drops the cycle after it is given
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_req = bus_req & wb_we_i;
  assign rd_req = bus_req & ~wb_we_i;

  // Word decode on the low address bits
  assign hit_ctrl = (wb_adr_i == `RTOT_ADDR_CTRL);
  assign hit_count = (wb_adr_i == `RTOT_ADDR_COUNT);
  assign hit_reload = (wb_adr_i == `RTOT_ADDR_RELOAD);
  assign hit_status = (wb_adr_i == `RTOT_ADDR_STATUS);

  // Plain increment; carry out is dropped so FFFF rolls to 0000
  assign count_inc = count_ff + `RTOT_COUNT_STEP; // [R1] [R3]

  // Match is tested on the tick that finds the count at reload.
  // Reload 0000 is reached only after the count wraps, the longest pass.
  assign match = (count_ff == reload_ff); // [R4] [R5]
  assign reload_evt = tick & match;
  assign oneshot_evt = reload_evt & (mode_ff == RTOT_MODE_ONESHOT);

  // Control register; the one-shot match drops the enable bit.
  // A write in the same cycle wins, so software can restart at once.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_ff <= 1'(`RTOT_CTRL_RST >> `RTOT_CTRL_EN_BIT);
      mode_ff <= RTOT_MODE_ONESHOT;
      presc_ff <= '0;
      output_polarity_select_ff <= 1'b0;
      out_en_ff <= 1'b0;
    end else if (wr_req & hit_ctrl & wb_sel_i[0]) begin
      en_ff <= wb_dat_i[`RTOT_CTRL_EN_BIT];
      mode_ff <= rtot_mode_e'(wb_dat_i[`RTOT_CTRL_MODE_BIT]);
      presc_ff <= wb_dat_i[`RTOT_CTRL_PRE_MSB:`RTOT_CTRL_PRE_LSB];
      output_polarity_select_ff <= wb_dat_i[`RTOT_CTRL_POL_BIT];
      out_en_ff <= wb_dat_i[`RTOT_CTRL_OUTEN_BIT];
    end else if (oneshot_evt) begin
      en_ff <= 1'b0; // [R7]
    end
  end

  // Count register: a software write sets the start of the next pass
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_ff <= `RTOT_COUNT_RST;
    end else if (wr_req & hit_count & (|wb_sel_i[1:0])) begin
      if (wb_sel_i[0]) begin
        count_ff[7:0] <= wb_dat_i[7:0]; // [R12]
      end
      if (wb_sel_i[1]) begin
        count_ff[15:8] <= wb_dat_i[15:8]; // [R12]
      end
    end else if (reload_evt) begin
      // Every pass after a match restarts from 0001
      count_ff <= `RTOT_COUNT_RESTART; // [R6] [R10] [R12] [R17]
    end else if (tick) begin
      count_ff <= count_inc; // [R1] [R3] [R16]
    end
  end

  // Reload register, byte-writable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_ff <= `RTOT_RELOAD_RST;
    end else if (wr_req & hit_reload) begin
      if (wb_sel_i[0]) begin
        reload_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        reload_ff[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Time-out request: one-cycle pulse per match, either mode
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= reload_evt; // [R6] [R10]
    end
  end

  // Held output level. Continuous mode keeps its own toggled level;
  // otherwise it follows the polarity bit, which sets the start level.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_ff <= 1'b0;
    end else if (en_ff & (mode_ff == RTOT_MODE_CONT)) begin
      level_ff <= level_ff ^ reload_evt; // [R11]
    end else begin
      level_ff <= output_polarity_select_ff;
    end
  end

  // Pin value. One-shot follows polarity live, so flipping it after
  // the start gives a lasting change; the match only inverts one cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= 1'b0;
    end else if (en_ff & (mode_ff == RTOT_MODE_CONT)) begin
      out_ff <= level_ff ^ reload_evt; // [R11]
    end else begin
      out_ff <= output_polarity_select_ff ^ oneshot_evt; // [R8] [R9]
    end
  end

  // Control byte as read back
  always_comb begin
    ctrl_rd = `RTOT_CTRL_RST;
    ctrl_rd[`RTOT_CTRL_EN_BIT] = en_ff;
    ctrl_rd[`RTOT_CTRL_MODE_BIT] = mode_ff;
    ctrl_rd[`RTOT_CTRL_PRE_MSB:`RTOT_CTRL_PRE_LSB] = presc_ff;
    ctrl_rd[`RTOT_CTRL_POL_BIT] = output_polarity_select_ff;
    ctrl_rd[`RTOT_CTRL_OUTEN_BIT] = out_en_ff;
  end

  // Read mux; unmapped words and upper bits read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_rdata[7:0] = ctrl_rd;
    end else if (hit_count) begin
      nxt_rdata[15:0] = count_ff;
    end else if (hit_reload) begin
      nxt_rdata[15:0] = reload_ff;
    end else if (hit_status) begin
      nxt_rdata[`RTOT_STAT_EN_BIT] = en_ff;
      nxt_rdata[`RTOT_STAT_OUT_BIT] = out_ff;
    end
  end

  // Bus answer one cycle after the strobe, reads and writes alike
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  // Read data captured with the answer, cleared otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_req) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // Output drivers, all straight from flip-flops
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign timer_irq_o = irq_ff;
  assign timer_out_o = out_ff;
  assign timer_out_oe_o = out_en_ff;

endmodule : rtot_timer

// File: bench/rtot_timer_monitor.sv
// Port checker for the reload timer
`timescale 1ns/1ps
module rtot_timer_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus and timer pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_irq_o,
  input wire logic timer_out_o,
  input wire logic timer_out_oe_o
);
  // Single domain, so one clocking and one reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Bus answers one cycle after the taking edge
  ack_next_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  // Read data zero outside a read answer
  idle_dat_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  write_dat_a:
    assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0) else $error("data on write");
  // Every reload flips the output in the request cycle
  irq_out_a:
    assert property (timer_irq_o |-> timer_out_o != $past(timer_out_o)) else $error("out not flipped");
  // Output moves only on a reload, its return, or a write
  out_cause_a:
    assert property ($changed(timer_out_o) |-> timer_irq_o || $past(timer_irq_o)
      || $past(wb_we_i && (wb_ack_o || wb_cyc_i && wb_stb_i))) else $error("out moved alone");
  oe_write_a:
    assert property ($changed(timer_out_oe_o) |-> $past(wb_we_i && (wb_ack_o || wb_cyc_i && wb_stb_i)))
      else $error("oe moved alone");
endmodule : rtot_timer_monitor

bind rtot_timer rtot_timer_monitor u_rtot_timer_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_irq_o(timer_irq_o), .timer_out_o(timer_out_o), .timer_out_oe_o(timer_out_oe_o));

// File: bench/test_rtot_timer.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
module test_rtot_timer;
  logic clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timer_irq_o, timer_out_o, timer_out_oe_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [3:0] adr_list [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  int n_errors = 0, cmp_count = 0, cyc = 0, te;
  rtot_timer u_rtot_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_irq_o(timer_irq_o), .timer_out_o(timer_out_o),
    .timer_out_oe_o(timer_out_oe_o));
  // Clock and edge counter
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Classic cycle; te keeps the taking edge, request held until ack
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    te = cyc;
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wait_irq;
    do @(posedge clk_i); while (timer_irq_o !== 1'b1);
  endtask : wait_irq
  // One timed pass: configure disabled, load, enable, time the requests
  task automatic run(input logic m, input logic [2:0] ex, input logic p, input logic [15:0] s,
    input logic [15:0] r);
    logic [6:0] c;
    logic [31:0] k;
    logic [31:0] pr;
    c = {1'b1, p, ex, m, 1'b0};
    pr = 32'h1 << ex;
    k = 32'(16'(r - s)) + 32'h1;
    bus(1'b1, 4'h0, 32'(c), 4'h1);
    bus(1'b1, 4'h4, 32'(s), 4'h3);
    bus(1'b1, 4'h8, 32'(r), 4'h3);
    bus(1'b1, 4'h0, 32'(c | 7'h1), 4'h1);
    chk("out enable", 32'h1, {31'h0, timer_out_oe_o});
    wait_irq();
    chk("first pass", k * pr + 32'h1, cyc - te);
    chk("out at reload", {31'h0, ~p}, {31'h0, timer_out_o});
    if (m) begin
      te = cyc;
      wait_irq();
      chk("later pass", (r == 16'h0 ? 32'h10000 : 32'(r)) * pr, cyc - te);
      chk("out held", {31'h0, p}, {31'h0, timer_out_o});
    end else begin
      @(posedge clk_i);
      chk("out back", {31'h0, p}, {31'h0, timer_out_o});
      bus(1'b0, 4'hc, 32'h0, 4'hf);
      chk("auto stop", 32'(p) << 1, rdat);
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk("count after reload", 32'h1, rdat);
    end
    bus(1'b1, 4'h0, 32'h0, 4'h1);
  endtask : run
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Watchdog sized for the full-range pass plus the short ones
  initial begin
    repeat (95000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
  // Main sequence: reset values, lanes, corner passes, random passes
  initial begin
    logic [15:0] r;
    logic [15:0] s;
    rst_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    void'($urandom(32'hc3342068));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (adr_list[i]) begin
      bus(1'b0, adr_list[i], 32'h0, 4'hf);
      chk("reset or unmapped read", 32'h0, rdat);
    end
    bus(1'b1, 4'h4, 32'h1234, 4'h3);
    bus(1'b1, 4'h4, 32'hffff, 4'h1);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk("low lane only", 32'h12ff, rdat);
    run(1'b1, 3'h0, 1'b0, 16'h0001, 16'h0001);
    run(1'b1, 3'h0, 1'b1, 16'hfffe, 16'h0000);
    run(1'b0, 3'h7, 1'b1, 16'h0005, 16'h0006);
    run(1'b0, 3'h0, 1'b0, 16'hfffe, 16'h0001);
    // Lasting one-shot level change: polarity flipped after the start
    bus(1'b1, 4'h0, 32'h40, 4'h1);
    bus(1'b1, 4'h4, 32'h1, 4'h3);
    bus(1'b1, 4'h8, 32'h14, 4'h3);
    bus(1'b1, 4'h0, 32'h41, 4'h1);
    bus(1'b1, 4'h0, 32'h61, 4'h1);
    wait_irq();
    chk("flip at reload", 32'h0, {31'h0, timer_out_o});
    @(posedge clk_i);
    chk("lasting level", 32'h1, {31'h0, timer_out_o});
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    // No external input pin exists, so nothing may toggle it
    repeat (8) begin
      r = 16'(1 + $urandom % 12);
      s = 16'(r - $urandom % 4);
      run(1'($urandom), 3'($urandom % 4), 1'($urandom), s, r);
    end
    report_and_stop();
  end
endmodule : test_rtot_timer
